/* rtl/scl_defs.svh */
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH

// ****************************************
// status byte layout
// ****************************************
`define SCL_STAT_RDY_HI 7
`define SCL_STAT_RDY_LO 6
`define SCL_STAT_ROUTER 5
`define SCL_STAT_COMM 4
`define SCL_STAT_REJECT 1
`define SCL_STAT_WDT 0
`define SCL_RDY_READY 2'h1
`define SCL_RDY_BUSY 2'h2
`define SCL_RDY_NOCONN 2'h3
`define SCL_STAT_RESET 8'h40

// ****************************************
// transfer framing
// ****************************************
`define SCL_MAX_DATA 5'h0F
`define SCL_ECHO_CMD 8'h01
`define SCL_BUF_DEPTH 2
`define SCL_LAST_BIT 3'h7

`endif

/* rtl/scl_pkg.sv */
package scl_pkg;

  typedef enum logic [3:0] {
    SCL_IDLE = 4'b0001,
    SCL_ADDR = 4'b0010,
    SCL_ACTIVE = 4'b0100,
    SCL_SKIP = 4'b1000
  } scl_state_t;

endpackage

/* rtl/scl_buf.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.svh"

module scl_buf #(
  parameter int W = 9,
  parameter int DEPTH = `SCL_BUF_DEPTH
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic do_wr, do_rd;

  // count is one bit wider than the pointers so that full is distinct
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_wr) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; valid is gated by count
  always_ff @(posedge mclk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule
`default_nettype wire

/* rtl/scl_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.svh"

module scl_slave #(
  parameter logic ADDR_EN = 1'b0,
  parameter logic IS_ROUTER = 1'b0,
  parameter logic [7:0] ECHO_CMD = `SCL_ECHO_CMD
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic link_sel_n_i,
  input wire logic link_mosi_i,
  output logic link_miso_o,
  input wire logic [7:0] node_addr_i,
  output logic [7:0] rx_data_o,
  output logic rx_first_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic busy_i,
  input wire logic reject_i,
  input wire logic wdt_exp_i,
  output logic selected_o,
  output logic txn_end_o,
  output logic [7:0] status_o
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] clk_sync;
  logic [1:0] sel_sync, mosi_sync;
  logic sclk_s, sclk_d, sel_s, mosi_s, rise, fall;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      clk_sync <= 3'h0;
      sel_sync <= 2'h0;
      mosi_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], link_clk_i};
      sel_sync <= {sel_sync[0], ~link_sel_n_i};
      mosi_sync <= {mosi_sync[0], link_mosi_i};
    end
  end

  // stage 1 feeds only stage 2; edges come from stages 2 and 3
  assign sclk_s = clk_sync[1];
  assign sclk_d = clk_sync[2];
  assign sel_s = sel_sync[1];
  assign mosi_s = mosi_sync[1];
  assign rise = sclk_s && !sclk_d;
  assign fall = !sclk_s && sclk_d;

  // ****************************************
  // shift engine
  // ****************************************
  scl_pkg::scl_state_t state, next_state;
  logic [6:0] rx_sh, next_rx_sh;
  logic [7:0] tx_sh, next_tx_sh, status, next_status, rx_byte, reply;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [4:0] byte_cnt, next_byte_cnt;
  logic loaded, next_loaded, echo, next_echo;
  logic comm_err, next_comm_err, rej, next_rej, end_p, next_end_p;
  logic byte_done, buf_valid, buf_ready, tx_pop;
  logic [8:0] buf_data;

  assign rx_byte = {rx_sh, mosi_s};
  assign byte_done = rise && (bit_cnt == `SCL_LAST_BIT);

  always_comb begin
    next_state = state;
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_status = status;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_loaded = loaded;
    next_echo = echo;
    next_comm_err = comm_err;
    next_rej = rej;
    next_end_p = 1'b0;
    buf_valid = 1'b0;
    buf_data = {1'b0, rx_byte};
    tx_pop = 1'b0;
    reply = 8'h00;
    if (!sel_s) begin
      next_state = scl_pkg::SCL_IDLE;
      next_rx_sh = 7'h00;
      next_tx_sh = 8'h00;
      next_bit_cnt = 3'h0;
      next_byte_cnt = 5'h00;
      next_loaded = 1'b0;
      next_echo = 1'b0;
      if (state == scl_pkg::SCL_ACTIVE) begin
        next_end_p = 1'b1;
        next_status[`SCL_STAT_RDY_HI:`SCL_STAT_RDY_LO] =
          busy_i ? `SCL_RDY_BUSY : `SCL_RDY_READY;
        next_status[`SCL_STAT_ROUTER] = IS_ROUTER;
        next_status[`SCL_STAT_COMM] = comm_err || (bit_cnt != 3'h0);
        next_status[3:2] = 2'h0;
        next_status[`SCL_STAT_REJECT] = rej || reject_i;
        next_status[`SCL_STAT_WDT] = wdt_exp_i;
        next_comm_err = 1'b0;
        next_rej = 1'b0;
      end
    end else if (state == scl_pkg::SCL_IDLE) begin
      next_state = ADDR_EN ? scl_pkg::SCL_ADDR : scl_pkg::SCL_ACTIVE;
      next_tx_sh = ADDR_EN ? 8'h00 : status;
      // without ADDR_EN, status bit 7 is on the line before the first rise, so no hold
      next_loaded = 1'b0;
    end else if (state != scl_pkg::SCL_SKIP) begin
      if (rise) begin
        next_rx_sh = rx_byte[6:0];
        next_bit_cnt = bit_cnt + 3'h1;
      end else if (fall) begin
        if (loaded) begin
          next_loaded = 1'b0;
        end else begin
          next_tx_sh = {tx_sh[6:0], 1'b0};
        end
      end
      if (byte_done && state == scl_pkg::SCL_ADDR) begin
        if (rx_byte == node_addr_i) begin
          next_state = scl_pkg::SCL_ACTIVE;
          next_tx_sh = status;
          next_loaded = 1'b1;
        end else begin
          next_state = scl_pkg::SCL_SKIP;
        end
      end else if (byte_done) begin
        buf_valid = 1'b1;
        buf_data = {byte_cnt == 5'h00, rx_byte};
        if (!buf_ready) begin
          next_comm_err = 1'b1;
        end
        if (byte_cnt == 5'h00) begin
          next_echo = (rx_byte == ECHO_CMD);
        end
        if (byte_cnt > `SCL_MAX_DATA) begin
          next_rej = 1'b1;
        end
        if (byte_cnt <= `SCL_MAX_DATA) begin
          next_byte_cnt = byte_cnt + 5'h01;
        end
        if (echo && byte_cnt != 5'h00) begin
          reply = rx_byte;
        end else if (!(byte_cnt == 5'h00 && rx_byte == ECHO_CMD)) begin
          reply = tx_valid_i ? tx_data_i : 8'h00;
          tx_pop = tx_valid_i;
        end
        next_tx_sh = reply;
        next_loaded = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= scl_pkg::SCL_IDLE;
      rx_sh <= 7'h00;
      tx_sh <= 8'h00;
      status <= `SCL_STAT_RESET;
      bit_cnt <= 3'h0;
      byte_cnt <= 5'h00;
      loaded <= 1'b0;
      echo <= 1'b0;
      comm_err <= 1'b0;
      rej <= 1'b0;
      end_p <= 1'b0;
    end else begin
      state <= next_state;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      status <= next_status;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      loaded <= next_loaded;
      echo <= next_echo;
      comm_err <= next_comm_err;
      rej <= next_rej;
      end_p <= next_end_p;
    end
  end

  // ****************************************
  // outputs and receive buffer
  // ****************************************
  // replies on master-in line
  assign link_miso_o = tx_sh[7];
  assign selected_o = (state == scl_pkg::SCL_ACTIVE);
  assign txn_end_o = end_p;
  assign status_o = status;
  assign tx_ready_o = tx_pop;

  // master cannot be stalled, so a full buffer shows as a comm error
  scl_buf #(
    .W(9),
    .DEPTH(`SCL_BUF_DEPTH)
  ) u_rx_buf (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(buf_valid),
    .in_ready_o(buf_ready),
    .in_data_i(buf_data),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o({rx_first_o, rx_data_o})
  );

  // ****************************************
  // checks
  // ****************************************
  chk_idle_reset: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !sel_s |=> state == scl_pkg::SCL_IDLE && tx_sh == 8'h00 && bit_cnt == 3'h0)
    else $error("shift state not cleared without select");
  chk_select_start: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    state == scl_pkg::SCL_IDLE && sel_s && !ADDR_EN
    |=> selected_o && tx_sh == $past(status))
    else $error("select did not start with old status");
  chk_sel_leave: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    state == scl_pkg::SCL_IDLE && sel_s |=> state != scl_pkg::SCL_IDLE)
    else $error("select did not leave idle");
  chk_status_prev: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    selected_o && !sel_s |=> txn_end_o && status[7:6] != 2'h0)
    else $error("status not latched at transaction end");
  chk_end_clear: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    txn_end_o |-> !rej && !comm_err)
    else $error("error flags not cleared after status latch");
  chk_status_fmt: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    txn_end_o |-> status[5] == IS_ROUTER && status[3:2] == 2'h0)
    else $error("status byte layout wrong");
  chk_status_ready: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    txn_end_o |-> status[0] == $past(wdt_exp_i) && status[7:6] ==
      ($past(busy_i) ? `SCL_RDY_BUSY : `SCL_RDY_READY))
    else $error("status ready or watchdog bits wrong");
  chk_drop_err: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    buf_valid && !buf_ready |=> comm_err)
    else $error("dropped byte not flagged");
  chk_echo_back: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    byte_done && selected_o && echo && byte_cnt != 5'h00 && sel_s
    |=> tx_sh == $past(rx_byte))
    else $error("echo byte not returned");
  chk_len_reject: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    byte_done && selected_o && sel_s && byte_cnt > 5'h0F |=> rej)
    else $error("overlong transfer not rejected");
  chk_msb_first: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    fall && !loaded && sel_s && selected_o
    |=> tx_sh == {$past(tx_sh[6:0]), 1'b0})
    else $error("reply not shifted msb first");
  chk_first_byte: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    buf_valid |-> buf_data[8] == (byte_cnt == 5'h00))
    else $error("command byte marker wrong");
  chk_idle_count: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    state == scl_pkg::SCL_IDLE |-> byte_cnt == 5'h00 && !loaded)
    else $error("byte count not cleared in idle");
  chk_tx_take: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    tx_ready_o |-> byte_done && tx_valid_i && selected_o)
    else $error("reply byte taken outside a byte slot");
  chk_conn_held: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    selected_o && sel_s ##1 sel_s |-> selected_o)
    else $error("connection dropped while selected");
  cov_echo: cover property (@(posedge mclk_i) echo && byte_done);
  cov_reject: cover property (@(posedge mclk_i) txn_end_o && status[1]);
  cov_skip: cover property (@(posedge mclk_i) state == scl_pkg::SCL_SKIP);
  cov_full_buf: cover property (@(posedge mclk_i) buf_valid && !buf_ready);
  cov_busy: cover property (@(posedge mclk_i) txn_end_o && status[7]);

endmodule
`default_nettype wire

/* verif/scl_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// master port model
// ****************************************
module scl_master_model (
  input wire logic mclk_i,
  output logic link_clk_o,
  output logic link_sel_n_o,
  output logic link_mosi_o,
  input wire logic link_miso_i
);
  // one card per port, only this side makes the clock
  initial begin
    link_clk_o = 1'b0;
    link_sel_n_o = 1'b1;
    link_mosi_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge mclk_i);
  endtask
  // select first, msb first, both lines each clock
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    @(negedge mclk_i);
    link_sel_n_o = 1'b0;
    half();
    half();
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        // commands out on mosi, replies back on miso
        link_mosi_o = tx[i][k];
        half();
        link_clk_o = 1'b1;
        b[k] = link_miso_i;
        half();
        link_clk_o = 1'b0;
      end
      rx.push_back(b);
    end
    half();
    link_sel_n_o = 1'b1;
    // released line must not keep showing its last bit
    link_mosi_o = ~link_mosi_o;
    half();
    half();
  endtask
  task automatic stray(input int n);
    repeat (n) begin
      half();
      link_clk_o = ~link_clk_o;
    end
  endtask
endmodule
`default_nettype wire

/* verif/test_select_clocked_serial_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.svh"
module test_select_clocked_serial_link;
  logic mclk_i, sys_rst_i, lclk, sel_n, mosi, miso;
  logic [7:0] rx_data, tx_data, status;
  logic rx_first, rx_valid, rx_ready, tx_valid, busy, reject, wdt;
  logic selected, txn_end, stall, tx_rdy;
  int err_total = 0, n_checks = 0, cyc = 0, ends = 0, pops = 0;
  int seed = 32'h842DEA33;
  localparam logic [7:0] node_addr = {2'h0, 3'h0, 3'h0};
  logic [8:0] exp_q[$];
  logic [7:0] tq[$], rq[$];
  scl_master_model m (.mclk_i(mclk_i), .link_clk_o(lclk),
    .link_sel_n_o(sel_n), .link_mosi_o(mosi), .link_miso_i(miso));
  scl_slave dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link_clk_i(lclk),
    .link_sel_n_i(sel_n), .link_mosi_i(mosi), .link_miso_o(miso),
    .node_addr_i(node_addr), .rx_data_o(rx_data), .rx_first_o(rx_first),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_rdy), .busy_i(busy),
    .reject_i(reject),
    .wdt_exp_i(wdt), .selected_o(selected), .txn_end_o(txn_end),
    .status_o(status));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // readiness 7:6, comm error 4, reject 1, watchdog 0
  function automatic logic [7:0] stat(input logic b, c, r, w);
    return {b ? 2'b10 : 2'b01, 1'b0, c, 2'b00, r, w};
  endfunction
  // receiver stalls at random, or fully while stall is set
  always @(negedge mclk_i) begin
    rx_ready <= stall ? 1'b0 : (($random(seed) & 3) != 0);
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (txn_end === 1'b1)
      ends++;
    if (tx_rdy === 1'b1)
      pops++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0)
        check({rx_first, rx_data}, 9'h1FF);
      else
        check({rx_first, rx_data}, exp_q.pop_front());
    end
    if (cyc > 10000) begin
      err_total++;
      results();
    end
  end
  task automatic txn(input logic [7:0] cmd, input int n, input logic tv,
      input logic [7:0] prev);
    logic [7:0] d;
    logic [7:0] e;
    d = 8'($random(seed));
    tq = {cmd};
    exp_q.push_back({1'b1, cmd});
    for (int i = 0; i < n; i++) begin
      tq.push_back(8'($random(seed)));
      exp_q.push_back({1'b0, tq[i+1]});
    end
    @(negedge mclk_i);
    tx_valid = tv;
    tx_data = d;
    m.frame(tq, rq);
    check({1'b0, rq[0]}, {1'b0, prev});
    for (int i = 1; i <= n; i++) begin
      e = (cmd == `SCL_ECHO_CMD) ? ((i == 1) ? 8'h00 : tq[i-1]) :
        (tv ? d : 8'h00);
      check({1'b0, rq[i]}, {1'b0, e});
    end
    $display("test cmd %h with %0d data bytes done", cmd, n);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    stall = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    busy = 1'b0;
    reject = 1'b0;
    wdt = 1'b0;
    repeat (6) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    m.stray(6);
    check({selected, 7'h00, rx_valid}, 9'h000);
    txn(`SCL_ECHO_CMD, 2, 1'b0, stat(0, 0, 0, 0));
    busy = 1'b1;
    wdt = 1'b1;
    txn(8'h22, 15, 1'b1, stat(0, 0, 0, 0));
    busy = 1'b0;
    wdt = 1'b0;
    reject = 1'b1;
    txn(8'h05, 0, 1'b1, stat(1, 0, 0, 1));
    reject = 1'b0;
    // sixteen data bytes overrun the limit
    txn(8'h33, 16, 1'b1, stat(0, 0, 1, 0));
    // full buffer drops the third byte and flags comm error
    stall = 1'b1;
    txn(8'h55, 2, 1'b0, stat(0, 0, 1, 0));
    void'(exp_q.pop_back());
    stall = 1'b0;
    txn(8'h44, 1, 1'b1, stat(0, 1, 0, 0));
    repeat (20) @(negedge mclk_i);
    check(9'(exp_q.size()), 9'h000);
    check(9'(ends), 9'h006);
    // one reply byte offered per byte slot while tx_valid is high
    check(9'(pops), 9'h024);
    check({1'b0, status}, {1'b0, stat(0, 0, 0, 0)});
    results();
  end
endmodule
`default_nettype wire
